// >>> hdl/dual_mode_host_interface.sv
// Function
// - Straps 0000 select serial mode, 010x select parallel mode.
// - Serial data input doubles as parallel address bit 0.
// - Serial data output pin becomes input address bit 1 in parallel mode.
// - Write strobe assertion latches the data bus into the addressed location.
// - Data bus used only in parallel mode; never driven in serial mode.
// - Interrupt output low while an unmasked event is pending, else high.
// - After reset release, 60.3 ms initialisation before any access.
// - Serial port supports modes 0 and 3; parallel has 2 address lines.
// - Power-down switches to low clock; cancel only after 300 ns.
`timescale 1ns/1ps
`include "hif_regs.svh"

module dual_mode_host_interface #(
    parameter int unsigned INIT_W = 24,
    parameter int unsigned INIT_CYCLES = int'(`CYC_LEAST(`INIT_TIME_NS))
) (
    // Clock and reset
    input wire logic core_clock_i,
    input wire logic rst_n_i,
    // Straps and reset pin
    input wire logic [3:0] iface_select_straps_i,
    input wire logic hard_reset_n_i,
    // Shared host pins
    input wire logic chip_select_n_i,
    input wire logic sclk_i,
    input wire logic mosi_bus_addr_bit0_i,
    input wire logic miso_i,
    output logic miso_o,
    output logic miso_oe_n_o,
    input wire logic read_strobe_n_i,
    input wire logic write_strobe_n_i,
    input wire logic [7:0] parallel_data_bus_i,
    output logic [7:0] parallel_data_bus_o,
    output logic parallel_data_bus_oe_n_o,
    output logic irq_out_n_o,
    // Core register access
    output logic [1:0] reg_addr_o,
    output logic reg_rd_o,
    input wire logic [7:0] reg_rd_data_i,
    output logic reg_wr_o,
    output logic [7:0] reg_wr_data_o,
    output logic [7:0] spi_rx_data_o,
    output logic spi_rx_valid_o,
    input wire logic [7:0] spi_tx_data_i,
    // Core status and interrupt sources
    output hif_pkg::host_mode_t host_mode_o,
    output logic core_reset_o,
    output logic core_ready_o,
    output logic strobe_conflict_o,
    input wire logic event_pending_i,
    input wire logic irq_pin_enable_i,
    // Power-down clock switch
    input wire logic phy_power_down_i,
    input wire logic phy_auto_reset_i,
    output logic core_clock_choice_o,
    output logic pd_settled_o,
    output logic phy_req_conflict_o
);
    import hif_pkg::*;

    localparam logic [6:0] RST_CYCLES = 7'(`CYC_LEAST(`RST_PULSE_NS));
    localparam logic [6:0] PD_CYCLES = 7'(`CYC_LEAST(`PD_SWITCH_NS));

    hif_pins_if pins ();

    hif_pin_sync u_sync (
        .core_clock_i(core_clock_i),
        .rst_n_i(rst_n_i),
        .cs_n_i(chip_select_n_i),
        .sclk_i(sclk_i),
        .mosi_i(mosi_bus_addr_bit0_i),
        .miso_i(miso_i),
        .rd_n_i(read_strobe_n_i),
        .wr_n_i(write_strobe_n_i),
        .hrst_n_i(hard_reset_n_i),
        .data_i(parallel_data_bus_i),
        .straps_i(iface_select_straps_i),
        .pins_o(pins.src)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Reset qualification, initialisation and mode latch

    logic [6:0] hrst_cnt_q;
    logic [INIT_W-1:0] init_cnt_q;
    logic ready_q;
    logic core_reset_q;
    host_mode_t mode_q;
    host_mode_t strap_mode;
    logic acc_en;

    assign strap_mode = (pins.straps == `STRAP_SERIAL) ? HOST_MODE_SERIAL :
                        (pins.straps[3:1] == `STRAP_PAR_HIGH) ? HOST_MODE_PARALLEL :
                        HOST_MODE_OFF;
    assign acc_en = ready_q && !core_reset_q;

    // pulse filter; short glitches only pause the init count
    always_ff @(posedge core_clock_i)
    begin
        if (!rst_n_i)
        begin
            hrst_cnt_q <= 7'h00;
            core_reset_q <= 1'b0;
            init_cnt_q <= '0;
            ready_q <= 1'b0;
        end
        else if (!pins.hrst_n)
        begin
            if (hrst_cnt_q != RST_CYCLES - 7'h01)
                hrst_cnt_q <= hrst_cnt_q + 7'h01;
            else
            begin
                core_reset_q <= 1'b1;
                ready_q <= 1'b0;
                init_cnt_q <= '0;
            end
        end
        else
        begin
            hrst_cnt_q <= 7'h00;
            core_reset_q <= 1'b0;
            if (!ready_q)
            begin
                init_cnt_q <= init_cnt_q + INIT_W'(1);
                ready_q <= (init_cnt_q == INIT_W'(INIT_CYCLES - 1));
            end
        end
    end

    // Straps are only followed while not ready, so a mid-run strap change is harmless
    always_ff @(posedge core_clock_i)
    begin
        if (!rst_n_i)
            mode_q <= HOST_MODE_OFF;
        else if (!acc_en)
            mode_q <= strap_mode;
    end

    assign host_mode_o = mode_q;
    assign core_reset_o = core_reset_q;
    assign core_ready_o = ready_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Parallel bus

    logic par_sel;
    logic rd_act;
    logic wr_act;
    logic rd_act_q;
    logic wr_act_q;
    logic rd_start;
    logic [7:0] rd_data_q;

    // read strobe only counts in parallel mode
    assign par_sel = acc_en && (mode_q == HOST_MODE_PARALLEL) && !pins.cs_n;
    assign rd_act = par_sel && !pins.rd_n && pins.wr_n;
    assign wr_act = par_sel && !pins.wr_n && pins.rd_n;
    assign strobe_conflict_o = par_sel && !pins.rd_n && !pins.wr_n;
    assign rd_start = rd_act && !rd_act_q;
    // address taken from the shared serial pins
    assign reg_addr_o = {pins.miso_in, pins.mosi};
    assign reg_rd_o = rd_start;
    assign reg_wr_o = wr_act && !wr_act_q;
    assign reg_wr_data_o = pins.data;

    // read data lands one edge after the synchronised strobe
    always_ff @(posedge core_clock_i)
    begin
        if (!rst_n_i)
        begin
            rd_act_q <= 1'b0;
            wr_act_q <= 1'b0;
            rd_data_q <= 8'h00;
        end
        else
        begin
            rd_act_q <= rd_act;
            wr_act_q <= wr_act;
            if (rd_start)
                rd_data_q <= reg_rd_data_i;
        end
    end

    // bus driven only during a parallel read
    assign parallel_data_bus_o = rd_data_q;
    assign parallel_data_bus_oe_n_o = !rd_act_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Serial port, modes 0 and 3

    logic ser_sel;
    logic sclk_q;
    logic sclk_rise;
    logic [2:0] bit_cnt_q;
    logic [7:0] rx_sh_q;
    logic [7:0] tx_sh_q;
    logic [7:0] rx_data_q;
    logic rx_valid_q;

    // serial clock is dead outside serial mode
    assign ser_sel = acc_en && (mode_q == HOST_MODE_SERIAL) && !pins.cs_n;
    assign sclk_rise = ser_sel && pins.sclk && !sclk_q;

    // both modes sample on the rising edge and advance output just after it
    always_ff @(posedge core_clock_i)
    begin
        if (!rst_n_i)
        begin
            sclk_q <= 1'b0;
            bit_cnt_q <= 3'h0;
            rx_sh_q <= 8'h00;
            tx_sh_q <= 8'h00;
            rx_data_q <= 8'h00;
            rx_valid_q <= 1'b0;
        end
        else
        begin
            sclk_q <= pins.sclk;
            rx_valid_q <= sclk_rise && (bit_cnt_q == 3'h7);
            if (!ser_sel)
            begin
                bit_cnt_q <= 3'h0;
                tx_sh_q <= spi_tx_data_i;
            end
            else if (sclk_rise)
            begin
                rx_sh_q <= {rx_sh_q[6:0], pins.mosi};
                bit_cnt_q <= bit_cnt_q + 3'h1;
                tx_sh_q <= (bit_cnt_q == 3'h7) ? spi_tx_data_i : {tx_sh_q[6:0], 1'b0};
                if (bit_cnt_q == 3'h7)
                    rx_data_q <= {rx_sh_q[6:0], pins.mosi};
            end
        end
    end

    // output pin driven only while selected in serial mode
    assign miso_o = tx_sh_q[7];
    assign miso_oe_n_o = !ser_sel;
    assign spi_rx_data_o = rx_data_q;
    assign spi_rx_valid_o = rx_valid_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt pin and power-down clock switch

    logic irq_n_q;
    pwr_state_t pwr_q;
    logic [6:0] pd_cnt_q;
    logic req_clash;

    // active low while an enabled event is pending
    always_ff @(posedge core_clock_i)
    begin
        if (!rst_n_i)
            irq_n_q <= 1'b1;
        else
            irq_n_q <= !(event_pending_i && irq_pin_enable_i);
    end
    assign irq_out_n_o = irq_n_q;

    // a clashing request is refused and flagged
    assign req_clash = phy_power_down_i && phy_auto_reset_i;

    // cancel is ignored until the switch time has run out
    always_ff @(posedge core_clock_i)
    begin
        if (!rst_n_i)
        begin
            pwr_q <= PWR_FAST;
            pd_cnt_q <= 7'h00;
            phy_req_conflict_o <= 1'b0;
        end
        else
        begin
            phy_req_conflict_o <= req_clash;
            case (pwr_q)
                PWR_FAST:
                begin
                    pd_cnt_q <= 7'h00;
                    if (phy_power_down_i && !req_clash)
                        pwr_q <= PWR_SWITCHING;
                end
                PWR_SWITCHING:
                begin
                    pd_cnt_q <= pd_cnt_q + 7'h01;
                    if (pd_cnt_q == PD_CYCLES - 7'h01)
                        pwr_q <= PWR_LOW;
                end
                PWR_LOW:
                    if (!phy_power_down_i)
                        pwr_q <= PWR_FAST;
                default:
                    pwr_q <= PWR_FAST;
            endcase
        end
    end

    assign core_clock_choice_o = (pwr_q != PWR_FAST);
    assign pd_settled_o = (pwr_q == PWR_LOW);

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge core_clock_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_read_start;
        rd_start;
    endsequence
    sequence s_data_driven;
        !parallel_data_bus_oe_n_o && (parallel_data_bus_o == $past(reg_rd_data_i));
    endsequence

    property p_strap_mode;
        !acc_en && (pins.straps == 4'h0) |=> mode_q == HOST_MODE_SERIAL;
    endproperty
    a_strap_mode: assert property (p_strap_mode) else $error("serial strap not taken");

    property p_serial_sample;
        sclk_rise |=> rx_sh_q[0] == $past(pins.mosi);
    endproperty
    a_serial_sample: assert property (p_serial_sample) else $error("serial bit lost");

    property p_miso_mode;
        !miso_oe_n_o |-> mode_q == HOST_MODE_SERIAL && parallel_data_bus_oe_n_o;
    endproperty
    a_miso_mode: assert property (p_miso_mode) else $error("output pin driven in parallel");

    property p_write_latch;
        par_sel && $fell(pins.wr_n) && pins.rd_n |-> reg_wr_o && reg_wr_data_o == pins.data;
    endproperty
    a_write_latch: assert property (p_write_latch) else $error("write strobe missed");

    property p_bus_quiet;
        mode_q != HOST_MODE_PARALLEL |-> parallel_data_bus_oe_n_o;
    endproperty
    a_bus_quiet: assert property (p_bus_quiet) else $error("data bus driven in serial");

    property p_irq_level;
        (event_pending_i && irq_pin_enable_i) |=> !irq_out_n_o;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt not raised");

    property p_reset_width;
        $rose(core_reset_o) |-> $past(!pins.hrst_n, 2) && hrst_cnt_q == RST_CYCLES - 7'h01;
    endproperty
    a_reset_width: assert property (p_reset_width) else $error("short reset pulse taken");

    property p_no_early_access;
        (reg_rd_o || reg_wr_o || spi_rx_valid_o) |-> core_ready_o;
    endproperty
    a_no_early_access: assert property (p_no_early_access) else $error("access before ready");

    property p_read_data;
        s_read_start ##1 rd_act |-> s_data_driven;
    endproperty
    a_read_data: assert property (p_read_data) else $error("read data late");

    property p_byte_done;
        sclk_rise && bit_cnt_q == 3'h7 |=> spi_rx_valid_o && bit_cnt_q == 3'h0;
    endproperty
    a_byte_done: assert property (p_byte_done) else $error("serial byte not flagged");

    property p_clash_refused;
        req_clash && pwr_q == PWR_FAST |=> pwr_q == PWR_FAST && phy_req_conflict_o;
    endproperty
    a_clash_refused: assert property (p_clash_refused) else $error("clashing request taken");

    property p_pd_wait;
        $rose(core_clock_choice_o) |-> (!pd_settled_o && core_clock_choice_o) [*8];
    endproperty
    a_pd_wait: assert property (p_pd_wait) else $error("power-down cancel too early");

    property p_strobe_clash;
        strobe_conflict_o |-> !reg_rd_o && !reg_wr_o;
    endproperty
    a_strobe_clash: assert property (p_strobe_clash) else $error("dual strobe accepted");

endmodule : dual_mode_host_interface

// >>> inc/hif_regs.svh
`ifndef HIF_REGS_SVH
`define HIF_REGS_SVH

// Strap codes: serial is all zeros, parallel matches bits 3:1 with bit 0 ignored
`define STRAP_SERIAL 4'h0
`define STRAP_PAR_HIGH 3'h2

// Core clock rate and documented times
`define CLK_MHZ 64'd250
`define RST_PULSE_NS 64'd500
`define INIT_TIME_NS 64'd60300000
`define PD_SWITCH_NS 64'd300

// Least time in ns rounded up to whole core clock cycles
`define CYC_LEAST(ns) ((((ns) * `CLK_MHZ) + 64'd999) / 64'd1000)

// Reset value of the synchroniser chain: strobes, select and reset pin idle high
`define SYNC_IDLE 19'h00071

`endif

// >>> inc/hif_pkg.sv
package hif_pkg;

    typedef enum logic [1:0] {
        HOST_MODE_OFF,
        HOST_MODE_SERIAL,
        HOST_MODE_PARALLEL
    } host_mode_t;

    typedef enum logic [1:0] {
        PWR_FAST,
        PWR_SWITCHING,
        PWR_LOW
    } pwr_state_t;

endpackage : hif_pkg

// >>> inc/hif_pins_if.sv
`timescale 1ns/1ps

// Host pins after synchronisation into the core clock domain
interface hif_pins_if;
    logic cs_n;
    logic sclk;
    logic mosi;
    logic miso_in;
    logic rd_n;
    logic wr_n;
    logic hrst_n;
    logic [7:0] data;
    logic [3:0] straps;

    modport src (output cs_n, sclk, mosi, miso_in, rd_n, wr_n, hrst_n, data, straps);
    modport dst (input cs_n, sclk, mosi, miso_in, rd_n, wr_n, hrst_n, data, straps);
endinterface : hif_pins_if

// >>> hdl/hif_pin_sync.sv
`timescale 1ns/1ps
`include "hif_regs.svh"

module hif_pin_sync (
    // Clock and reset
    input wire logic core_clock_i,
    input wire logic rst_n_i,
    // Raw host pins
    input wire logic cs_n_i,
    input wire logic sclk_i,
    input wire logic mosi_i,
    input wire logic miso_i,
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    input wire logic hrst_n_i,
    input wire logic [7:0] data_i,
    input wire logic [3:0] straps_i,
    // Synchronised copies
    hif_pins_if.src pins_o
);

    logic [18:0] meta_q;
    logic [18:0] sync_q;
    logic [18:0] raw;

    assign raw = {straps_i, data_i, hrst_n_i, wr_n_i, rd_n_i, miso_i, mosi_i, sclk_i, cs_n_i};

    // Two stages; only the second stage is read by the core
    always_ff @(posedge core_clock_i)
    begin
        if (!rst_n_i)
        begin
            meta_q <= `SYNC_IDLE;
            sync_q <= `SYNC_IDLE;
        end
        else
        begin
            meta_q <= raw;
            sync_q <= meta_q;
        end
    end

    assign pins_o.cs_n = sync_q[0];
    assign pins_o.sclk = sync_q[1];
    assign pins_o.mosi = sync_q[2];
    assign pins_o.miso_in = sync_q[3];
    assign pins_o.rd_n = sync_q[4];
    assign pins_o.wr_n = sync_q[5];
    assign pins_o.hrst_n = sync_q[6];
    assign pins_o.data = sync_q[14:7];
    assign pins_o.straps = sync_q[18:15];

endmodule : hif_pin_sync

// >>> tb/host_model.sv
`timescale 1ns/1ps

module host_model (
    // Clock
    input wire logic core_clock_i,
    // Host side of the pins
    output logic cs_n_o,
    output logic sclk_o,
    output logic mosi_a0_o,
    output logic a1_o,
    output logic rd_n_o,
    output logic wr_n_o,
    output logic [7:0] data_o,
    input wire logic [7:0] data_i,
    input wire logic miso_i
);

    initial
    begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        mosi_a0_o = 1'b0;
        a1_o = 1'b0;
        rd_n_o = 1'b1;
        wr_n_o = 1'b1;
        data_o = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////
    // Every pin change lands 1 ns after a core clock edge
    task automatic tick(input int n);
        repeat (n) @(posedge core_clock_i);
        #1;
    endtask : tick

    task automatic par_write(input logic [1:0] a, input logic [7:0] d);
        {a1_o, mosi_a0_o} = a;
        data_o = d;
        cs_n_o = 1'b0;
        tick(2);
        wr_n_o = 1'b0;
        tick(5);
        wr_n_o = 1'b1;
        cs_n_o = 1'b1;
        // Released bus shows the inverse so stale data cannot pass
        data_o = ~d;
        tick(3);
    endtask : par_write

    task automatic par_read(input logic [1:0] a, output logic [7:0] d);
        {a1_o, mosi_a0_o} = a;
        cs_n_o = 1'b0;
        rd_n_o = 1'b0;
        tick(3);
        d = data_i;
        tick(2);
        rd_n_o = 1'b1;
        cs_n_o = 1'b1;
        tick(3);
    endtask : par_read

    // deliberate strobe clash, only on command
    task automatic par_clash(input logic on);
        cs_n_o = !on;
        rd_n_o = !on;
        wr_n_o = !on;
        tick(1);
    endtask : par_clash

    // one byte in mode 0 or 3, clock still outside frames
    task automatic spi_xfer(input logic cpol, input logic [7:0] tx, output logic [7:0] rx);
        sclk_o = cpol;
        tick(2);
        cs_n_o = 1'b0;
        tick(4);
        for (int i = 7; i >= 0; i--)
        begin
            sclk_o = 1'b0;
            mosi_a0_o = tx[i];
            tick(8);
            rx[i] = miso_i;
            sclk_o = 1'b1;
            tick(8);
        end
        sclk_o = cpol;
        mosi_a0_o = ~mosi_a0_o;
        tick(4);
        cs_n_o = 1'b1;
        tick(3);
    endtask : spi_xfer

endmodule : host_model

// >>> tb/tb.sv
`timescale 1ns/1ps

module tb;
    import hif_pkg::*;

    localparam int INIT = 50;
    localparam int LIMIT = 20000;

    logic core_clock_i, rst_n_i, hrst_n, ev, irq_en, pd, ar;
    logic [3:0] straps;
    logic [7:0] spi_tx, d, rx_last;
    logic cs_n, sclk, mosi, a1, rd_n, wr_n, miso_o, miso_oe_n, bus_oe_n, reg_rd, reg_wr;
    logic rx_valid, core_reset, ready, clash, clk_sel, settled, req_clash, irq_n;
    logic [7:0] hdata, bus_o, rd_data, wr_data, rx_data;
    logic [1:0] reg_addr;
    logic miso_pin, bad_miso, bad_bus;
    logic [7:0] bus_pin;
    logic [9:0] wr_last;
    host_mode_t mode;
    int error_cnt, samples_checked, cyc, wr_cnt, rd_cnt, t0, n;

    // Shared pins resolve from the low-active enables
    assign miso_pin = !miso_oe_n ? miso_o : a1;
    assign bus_pin = !bus_oe_n ? bus_o : hdata;
    assign rd_data = 8'hA5 ^ {6'h00, reg_addr};

    ////////////////////////////////////////////////////////////////////////
    host_model u_host (.core_clock_i(core_clock_i), .cs_n_o(cs_n), .sclk_o(sclk), .mosi_a0_o(mosi),
        .a1_o(a1), .rd_n_o(rd_n), .wr_n_o(wr_n), .data_o(hdata), .data_i(bus_pin),
        .miso_i(miso_pin));

    dual_mode_host_interface #(.INIT_CYCLES(INIT)) dut (.core_clock_i(core_clock_i),
        .rst_n_i(rst_n_i), .iface_select_straps_i(straps), .hard_reset_n_i(hrst_n),
        .chip_select_n_i(cs_n), .sclk_i(sclk), .mosi_bus_addr_bit0_i(mosi), .miso_i(miso_pin),
        .miso_o(miso_o), .miso_oe_n_o(miso_oe_n), .read_strobe_n_i(rd_n),
        .write_strobe_n_i(wr_n), .parallel_data_bus_i(bus_pin), .parallel_data_bus_o(bus_o),
        .parallel_data_bus_oe_n_o(bus_oe_n), .irq_out_n_o(irq_n), .reg_addr_o(reg_addr),
        .reg_rd_o(reg_rd), .reg_rd_data_i(rd_data), .reg_wr_o(reg_wr),
        .reg_wr_data_o(wr_data), .spi_rx_data_o(rx_data), .spi_rx_valid_o(rx_valid),
        .spi_tx_data_i(spi_tx), .host_mode_o(mode), .core_reset_o(core_reset),
        .core_ready_o(ready), .strobe_conflict_o(clash), .event_pending_i(ev),
        .irq_pin_enable_i(irq_en), .phy_power_down_i(pd), .phy_auto_reset_i(ar),
        .core_clock_choice_o(clk_sel), .pd_settled_o(settled), .phy_req_conflict_o(req_clash));

    // Clock at 250 MHz
    initial
    begin
        core_clock_i = 1'b0;
        forever #2 core_clock_i = ~core_clock_i;
    end

    // Pulse monitor and hang guard; the limit is far above the planned run
    always @(posedge core_clock_i)
    begin
        cyc++;
        if (reg_wr === 1'b1)
        begin
            wr_cnt++;
            wr_last = {reg_addr, wr_data};
        end
        if (reg_rd === 1'b1)
            rd_cnt++;
        if (rx_valid === 1'b1)
            rx_last = rx_data;
        if (mode == HOST_MODE_PARALLEL && miso_oe_n !== 1'b1)
            bad_miso = 1'b1;
        if (mode == HOST_MODE_SERIAL && bus_oe_n !== 1'b1)
            bad_bus = 1'b1;
        if (cyc == LIMIT)
        begin
            error_cnt++;
            end_sim();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic step(input int k);
        repeat (k) @(posedge core_clock_i);
        #1;
    endtask : step

    // Bounded wait for the end of the start-up interval
    task automatic wait_ready();
        n = 0;
        while (ready !== 1'b1 && n < 400)
        begin
            step(1);
            n++;
        end
    endtask : wait_ready

    task automatic end_sim();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_sim

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        {rst_n_i, ev, irq_en, pd, ar, bad_miso, bad_bus} = 7'h00;
        hrst_n = 1'b1;
        straps = 4'h5;
        spi_tx = 8'h00;
        step(8);
        rst_n_i = 1'b1;
        t0 = cyc;
        check("irq idle", irq_n, 1'b1);
        u_host.par_write(2'h1, 8'h3C);
        check("early write", wr_cnt, 0);
        wait_ready();
        check("init time", (cyc - t0 >= INIT) && (cyc - t0 <= INIT + 6), 1'b1);
        check("mode par", mode, HOST_MODE_PARALLEL);
        for (int a = 0; a < 4; a++)
        begin
            u_host.par_write(a[1:0], 8'hC0 + 8'(a));
            check("write count", wr_cnt, a + 1);
            check("write addr data", wr_last, {a[1:0], 8'hC0 + 8'(a)});
            u_host.par_read(a[1:0], d);
            check("read data", d, 8'hA5 ^ 8'(a));
            check("read count", rd_cnt, a + 1);
        end
        check("miso quiet", bad_miso, 1'b0);
        u_host.par_clash(1'b1);
        step(4);
        check("clash flag", clash, 1'b1);
        u_host.par_clash(1'b0);
        step(3);
        check("clash refused", wr_cnt + rd_cnt, 8);
        for (int i = 0; i < 4; i++)
        begin
            {ev, irq_en} = i[1:0];
            step(2);
            check("irq level", irq_n, i != 3);
        end
        pd = 1'b1;
        step(2);
        check("low clock", clk_sel, 1'b1);
        pd = 1'b0;
        step(2);
        check("early cancel", {clk_sel, settled}, 2'h2);
        // Switch started 3 edges ago; 300 ns is 75 edges in all
        pd = 1'b1;
        step(71);
        check("switch time", settled, 1'b0);
        step(1);
        check("settled", settled, 1'b1);
        pd = 1'b0;
        step(2);
        check("fast clock", clk_sel, 1'b0);
        {pd, ar} = 2'h3;
        step(2);
        check("req clash", {req_clash, clk_sel}, 2'h2);
        {pd, ar} = 2'h0;
        hrst_n = 1'b0;
        step(100);
        hrst_n = 1'b1;
        step(3);
        check("short reset", {core_reset, ready}, 2'h1);
        straps = 4'h0;
        hrst_n = 1'b0;
        step(135);
        check("long reset", {core_reset, ready}, 2'h2);
        hrst_n = 1'b1;
        t0 = cyc;
        wait_ready();
        check("reinit time", (cyc - t0 >= INIT) && (cyc - t0 <= INIT + 6), 1'b1);
        check("mode ser", mode, HOST_MODE_SERIAL);
        for (int m = 0; m < 2; m++)
        begin
            spi_tx = m ? 8'h5A : 8'hC3;
            u_host.spi_xfer(m[0], m ? 8'h81 : 8'h96, d);
            check("miso byte", d, spi_tx);
            check("mosi byte", rx_last, m ? 8'h81 : 8'h96);
        end
        check("bus quiet", bad_bus, 1'b0);
        end_sim();
    end

endmodule : tb
